/* core/dram_refresh_timer.sv */
// refresh timer, control registers and ahb-lite slave for the dram refresh
`timescale 1ns/1ps
module dram_refresh_timer
	import refresh_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	output logic             irq,
	output logic             dram_ras_n,
	output logic             dram_cas_n
);

	// ==========================================================
	// declarations
	// ==========================================================
	refresh_if rif ();                 // link to the strobe sequencer
	logic [7:0]      counter_q;       // refresh_counter
	logic [7:0]      period_q;        // refresh_period_constant
	logic [2:0]      ctrl_q;          // mode, wait, enable
	logic            cmf_q;           // compare_match_flag
	logic            armed_q;         // flag was read while set
	logic [EV_W-1:0] ev_st_q;         // sticky interrupt status
	logic [EV_W-1:0] ev_msk_q;        // interrupt mask
	logic            irq_q;           // registered interrupt line
	logic            req_q;           // refresh request to the sequencer
	logic            wr_pend_q;       // write data phase pending
	logic [15:0]     widx_q;          // register index of that write
	logic [31:0]     hrdata_q;        // read data for the data phase
	logic            addr_ok;         // address falls in our index window
	logic [15:0]     aidx;            // index of the address phase
	logic            take;            // address phase accepted this edge
	logic            match;           // counter equals period
	logic            wr_cnt;          // data phase write to counter
	logic            wr_per;          // data phase write to period
	logic            wr_ctl;          // data phase write to control
	logic            wr_flag;         // data phase write to flag
	logic            wr_ist;          // data phase write to status
	logic            wr_msk;          // data phase write to mask
	logic            rd_flag;         // address phase read of flag
	logic [EV_W-1:0] ev_set;          // events raised this cycle

	// ==========================================================
	// bus decode
	// ==========================================================
	// the slave never stalls, so a selected nonseq address phase is taken at every hready
	assign take    = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign aidx    = haddr[17:2];
	assign addr_ok = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'h0);
	assign wr_cnt  = wr_pend_q && (widx_q == IDX_COUNTER);
	assign wr_per  = wr_pend_q && (widx_q == IDX_PERIOD);
	assign wr_ctl  = wr_pend_q && (widx_q == IDX_CTRL);
	assign wr_flag = wr_pend_q && (widx_q == IDX_FLAG);
	assign wr_ist  = wr_pend_q && (widx_q == IDX_IRQ_ST);
	assign wr_msk  = wr_pend_q && (widx_q == IDX_IRQ_MSK);
	assign rd_flag = take && !hwrite && addr_ok && (aidx == IDX_FLAG);
	assign match   = (counter_q == period_q);

	// write data phase tracking; unmapped writes simply land nowhere
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			widx_q    <= 16'h0000;
		end else begin
			wr_pend_q <= take && hwrite && addr_ok;
			widx_q    <= aidx;
		end
	end

	// read data captured at the address edge, shown in the data phase
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hrdata_q <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata_q <= 32'h0000_0000;
			if (addr_ok) begin
				unique case (aidx)
					IDX_COUNTER: hrdata_q[7:0] <= counter_q;
					IDX_PERIOD:  hrdata_q[7:0] <= period_q;
					IDX_CTRL:    hrdata_q[2:0] <= ctrl_q;
					IDX_FLAG:    hrdata_q[FLAG_CMF_BIT] <= cmf_q;
					IDX_IRQ_ST:  hrdata_q[EV_W-1:0] <= ev_st_q;
					IDX_IRQ_MSK: hrdata_q[EV_W-1:0] <= ev_msk_q;
					default:     hrdata_q <= 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end

	// zero-wait slave with okay answers only
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
		end
	end

	assign hrdata = hrdata_q;

	// ==========================================================
	// refresh timer
	// ==========================================================
	// counter runs on every clock; a software write wins over counting
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			counter_q <= COUNTER_RST;
		end else if (wr_cnt) begin
			counter_q <= hwdata[7:0];
		end else if (match) begin
			counter_q <= COUNTER_RST;
		end else begin
			counter_q <= counter_q + 8'h01;
		end
	end

	// period constant and control bits
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			period_q <= PERIOD_RST;
			ctrl_q   <= CTRL_RST;
		end else begin
			if (wr_per) begin
				period_q <= hwdata[7:0];
			end
			if (wr_ctl) begin
				ctrl_q <= hwdata[2:0];
			end
		end
	end

	// compare match flag: set wins over the read-then-write-zero clear
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cmf_q   <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			if (match) begin
				cmf_q <= 1'b1;
			end else if (wr_flag && armed_q && !hwdata[FLAG_CMF_BIT]) begin
				cmf_q <= 1'b0;
			end
			// the arm lasts until the next write to the flag register
			if (rd_flag && cmf_q) begin
				armed_q <= 1'b1;
			end else if (wr_flag) begin
				armed_q <= 1'b0;
			end
		end
	end

	// one refresh request per match while refresh control is on
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			req_q <= 1'b0;
		end else begin
			req_q <= match && ctrl_q[CTRL_EN_BIT];
		end
	end

	// ==========================================================
	// interrupts
	// ==========================================================
	assign ev_set[EV_MATCH_BIT] = match;
	assign ev_set[EV_DONE_BIT]  = rif.done;

	// sticky status, write one to clear, new events win
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ev_st_q  <= EV_RST;
			ev_msk_q <= EV_RST;
		end else begin
			ev_st_q <= ev_set
				| (ev_st_q & ~(wr_ist ? hwdata[EV_W-1:0] : EV_RST));
			if (wr_msk) begin
				ev_msk_q <= hwdata[EV_W-1:0];
			end
		end
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(ev_st_q & ev_msk_q);
		end
	end

	assign irq = irq_q;

	// ==========================================================
	// strobe sequencer
	// ==========================================================
	assign rif.req       = req_q;
	assign rif.enable    = ctrl_q[CTRL_EN_BIT];
	assign rif.self_mode = ctrl_q[CTRL_SELF_BIT];
	assign rif.wait_en   = ctrl_q[CTRL_WAIT_BIT];

	refresh_sequencer u_seq (
		.clk_sys (clk_sys),
		.rst     (rst),
		.rif     (rif)
	);

	assign dram_ras_n = rif.ras_n;
	assign dram_cas_n = rif.cas_n;

	// ==========================================================
	// checks
	// ==========================================================
	chk_count_up: assert property (@(posedge clk_sys) disable iff (rst)
		(!match && !wr_cnt) |=> (counter_q == $past(counter_q) + 8'h01))
		else $error("refresh counter did not advance by one");

	chk_match_wrap: assert property (@(posedge clk_sys) disable iff (rst)
		(match && !wr_cnt) |=> (counter_q == 8'h00))
		else $error("refresh counter not cleared on compare match");

	chk_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
		match |=> cmf_q)
		else $error("compare match flag not set on match");

	chk_flag_clear_armed: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(cmf_q) |-> $past(armed_q) && $past(wr_flag))
		else $error("compare match flag cleared without prior read");

	chk_flag_clear_done: assert property (@(posedge clk_sys) disable iff (rst)
		(armed_q && wr_flag && !hwdata[FLAG_CMF_BIT] && !match) |=> !cmf_q)
		else $error("compare match flag not cleared after read then write zero");

	chk_req_on_match: assert property (@(posedge clk_sys) disable iff (rst)
		(match && ctrl_q[CTRL_EN_BIT]) |=> req_q ##1 !req_q || match)
		else $error("refresh request missing after compare match");

	chk_no_req_disabled: assert property (@(posedge clk_sys) disable iff (rst)
		!ctrl_q[CTRL_EN_BIT] |=> !req_q)
		else $error("refresh request issued while refresh control is off");

	chk_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
		(|(ev_st_q & ev_msk_q)) |=> irq_q)
		else $error("interrupt line low with unmasked status set");

	// register writes land at the edge that ends their data phase
	chk_cnt_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_cnt |=> (counter_q == $past(hwdata[7:0])))
		else $error("refresh counter write did not land");

	chk_per_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_per |=> (period_q == $past(hwdata[7:0])))
		else $error("period constant write did not land");

	chk_per_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!wr_per |=> $stable(period_q))
		else $error("period constant changed without a write");

	chk_ctl_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_ctl |=> (ctrl_q == $past(hwdata[2:0])))
		else $error("control bits write did not land");

	// a counter read shows the value held at the address edge
	chk_cnt_read: assert property (@(posedge clk_sys) disable iff (rst)
		(take && !hwrite && addr_ok && (aidx == IDX_COUNTER))
			|=> (hrdata_q == {24'h000000, $past(counter_q)}))
		else $error("refresh counter read returned a wrong value");

	chk_flag_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(cmf_q && !(wr_flag && armed_q)) |=> cmf_q)
		else $error("compare match flag dropped without an armed write");

	chk_req_cause: assert property (@(posedge clk_sys) disable iff (rst)
		req_q |-> ($past(match) && $past(ctrl_q[CTRL_EN_BIT])))
		else $error("refresh request without an enabled compare match");

	chk_status_set: assert property (@(posedge clk_sys) disable iff (rst)
		match |=> ev_st_q[EV_MATCH_BIT])
		else $error("match event not recorded in status");

	chk_status_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(wr_ist && hwdata[EV_MATCH_BIT] && !match) |=> !ev_st_q[EV_MATCH_BIT])
		else $error("match status not cleared by writing one");

	chk_irq_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		!(|(ev_st_q & ev_msk_q)) |=> !irq_q)
		else $error("interrupt line high with no unmasked status");

endmodule

/* core/refresh_pkg.sv */
// shared constants and types for the dram refresh timer and its sequencer
package refresh_pkg;

	// ==========================================================
	// register indexes (byte address is four times the index)
	// ==========================================================
	localparam logic [15:0] IDX_CTRL    = 16'hfed7; // refresh control bits
	localparam logic [15:0] IDX_COUNTER = 16'hfed8; // refresh_counter
	localparam logic [15:0] IDX_PERIOD  = 16'hfed9; // refresh_period_constant
	localparam logic [15:0] IDX_FLAG    = 16'hfeda; // compare_match_flag
	localparam logic [15:0] IDX_IRQ_ST  = 16'hfedc; // sticky event status
	localparam logic [15:0] IDX_IRQ_MSK = 16'hfedd; // event mask

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int CTRL_SELF_BIT = 0; // 0 cas-before-ras, 1 self-refresh
	localparam int CTRL_WAIT_BIT = 1; // one wait state in cas-before-ras
	localparam int CTRL_EN_BIT   = 2; // refresh control enable
	localparam int FLAG_CMF_BIT  = 0; // compare match flag
	localparam int EV_MATCH_BIT  = 0; // event: compare match
	localparam int EV_DONE_BIT   = 1; // event: refresh cycle finished
	localparam int EV_W          = 2; // number of interrupt events

	// ==========================================================
	// values after reset
	// ==========================================================
	localparam logic [7:0]      COUNTER_RST = 8'h00;
	localparam logic [7:0]      PERIOD_RST  = 8'hff;
	localparam logic [2:0]      CTRL_RST    = 3'h0;
	localparam logic [EV_W-1:0] EV_RST      = 2'h0;

	// ==========================================================
	// ahb encodings
	// ==========================================================
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	// sequencer states
	typedef enum logic [2:0] {
		st_idle,
		st_row,
		st_col1,
		st_wait,
		st_col2,
		st_self
	} seq_state_t;

endpackage

/* core/refresh_if.sv */
// link between the refresh timer and the dram strobe sequencer
`timescale 1ns/1ps
interface refresh_if;
	logic req;       // one-cycle refresh request
	logic enable;    // refresh control enable
	logic self_mode; // self-refresh selected
	logic wait_en;   // wait state in cas-before-ras
	logic ras_n;     // row strobe, active low
	logic cas_n;     // column strobe, active low
	logic done;      // one-cycle pulse at end of a refresh cycle

	modport ctrl (output req, enable, self_mode, wait_en, input ras_n, cas_n, done);
	modport seq  (input req, enable, self_mode, wait_en, output ras_n, cas_n, done);
endinterface

/* core/refresh_sequencer.sv */
// cas-before-ras and self-refresh strobe sequencer
`timescale 1ns/1ps
module refresh_sequencer
	import refresh_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	refresh_if.seq    rif
);

	// ==========================================================
	// state
	// ==========================================================
	seq_state_t state_q;    // current strobe state
	seq_state_t state_d;    // next strobe state
	logic       wait_cur_q; // wait choice frozen for the running cycle
	logic       ras_n_q;    // registered row strobe
	logic       cas_n_q;    // registered column strobe
	logic       done_q;     // end-of-cycle pulse

	// next state decode
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			st_idle: begin
				if (rif.enable && rif.self_mode) begin
					state_d = st_self;
				end else if (rif.enable && rif.req) begin
					state_d = st_row;
				end
			end
			st_row:  state_d = st_col1;
			st_col1: state_d = wait_cur_q ? st_wait : st_col2;
			st_wait: state_d = st_col2;
			st_col2: state_d = st_idle;
			st_self: begin
				// leave self-refresh as soon as it is deselected or disabled
				if (!(rif.enable && rif.self_mode)) begin
					state_d = st_idle;
				end
			end
		endcase
	end

	// state register and frozen wait choice
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q    <= st_idle;
			wait_cur_q <= 1'b0;
		end else begin
			state_q <= state_d;
			if (state_q == st_idle) begin
				// a write mid-cycle must not reshape the running cycle
				wait_cur_q <= rif.wait_en;
			end
		end
	end

	// strobes follow the next state so pins change with the state itself
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ras_n_q <= 1'b1;
			cas_n_q <= 1'b1;
			done_q  <= 1'b0;
		end else begin
			// cas falls no later than ras; ras falls in row state or first column state
			cas_n_q <= !(state_d inside {st_row, st_col1, st_wait, st_self});
			ras_n_q <= !((state_d == st_row && !rif.wait_en && state_q == st_idle)
				|| (state_d inside {st_col1, st_wait, st_col2, st_self}));
			done_q  <= (state_q == st_col2);
		end
	end

	assign rif.ras_n = ras_n_q;
	assign rif.cas_n = cas_n_q;
	assign rif.done  = done_q;

	// ==========================================================
	// checks
	// ==========================================================
	sequence s_cbr_plain;
		state_q == st_row ##1 state_q == st_col1 ##1 state_q == st_col2
			##1 state_q == st_idle;
	endsequence

	sequence s_cbr_wait;
		state_q == st_row ##1 state_q == st_col1 ##1 state_q == st_wait
			##1 state_q == st_col2 ##1 state_q == st_idle;
	endsequence

	chk_row_ras_low: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == st_row && !wait_cur_q) |-> (!ras_n_q && !cas_n_q))
		else $error("row strobe not low in row state without wait");

	chk_wait_ras_late: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == st_row && wait_cur_q) |-> (ras_n_q ##1 !ras_n_q))
		else $error("row strobe did not fall in first column state");

	chk_cbr_no_wait: assert property (@(posedge clk_sys) disable iff (rst)
		($rose(state_q == st_row) && !wait_cur_q) |-> s_cbr_plain)
		else $error("cas-before-ras cycle without wait has wrong length");

	chk_cbr_one_wait: assert property (@(posedge clk_sys) disable iff (rst)
		($rose(state_q == st_row) && wait_cur_q) |-> s_cbr_wait)
		else $error("cas-before-ras cycle with wait has wrong length");

	chk_self_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == st_self) |-> (!ras_n_q && !cas_n_q && rif.done == 1'b0))
		else $error("self-refresh does not hold both strobes low");

	chk_disabled_idle: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == st_idle && !rif.enable) |=> (state_q == st_idle && ras_n_q))
		else $error("refresh activity while refresh control is off");

endmodule

/* bench/dram_model.sv */
// behavioural external dram that watches the refresh strobes
`timescale 1ns/1ps
module dram_model (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic ras_n,
	input  wire logic cas_n,
	output int        cbr_cnt,
	output int        gap,
	output int        cas_to_ras,
	output int        cas_w,
	output int        ras_w
);
	int   cyc;    // free-running clock count
	int   cas_t;  // clock of the last refresh start
	int   cas_lo; // clocks cas has been low so far
	int   ras_lo; // clocks ras has been low so far
	logic ras_d;  // strobes one clock back
	logic cas_d;

	// ==========================================================
	// strobe watcher
	// ==========================================================
	// a real part latches its strobes on the edge, so does this one
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cyc = 0;
			cas_t = 0;
			cbr_cnt = 0;
			cas_lo = 0;
			ras_lo = 0;
			ras_d = 1'b1;
			cas_d = 1'b1;
		end else begin
			cyc = cyc + 1;
			// cas no later than ras: refresh, never a plain access
			if (cas_d && !cas_n && ras_d) begin
				gap = cyc - cas_t;
				cas_t = cyc;
				cbr_cnt = cbr_cnt + 1;
			end
			// the lag of ras behind cas is the wait state
			if (ras_d && !ras_n)
				cas_to_ras = cyc - cas_t;
			if (!cas_d && cas_n)
				cas_w = cas_lo;
			if (!ras_d && ras_n)
				ras_w = ras_lo;
			cas_lo = cas_n ? 0 : cas_lo + 1;
			ras_lo = ras_n ? 0 : ras_lo + 1;
			ras_d = ras_n;
			cas_d = cas_n;
		end
	end
endmodule

/* bench/tb_top.sv */
// self-checking bench for the dram refresh timer
`timescale 1ns/1ps
module tb_top;
	import refresh_pkg::*;

	logic        clk_sys;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        irq;
	logic        ras_n;
	logic        cas_n;
	int          cbr_cnt;
	int          gap;
	int          cas_to_ras;
	int          cas_w;
	int          ras_w;
	int          error_cnt;
	int          total_checks;
	logic [31:0] mreg [int]; // register contents as the model expects them
	logic [31:0] rd;
	logic [31:0] en_b;
	int          p;
	int          v;
	int          snap;

	dram_refresh_timer dram_refresh_timer_inst (
		.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.dram_ras_n(ras_n), .dram_cas_n(cas_n)
	);

	dram_model dram_model_inst (
		.clk_sys(clk_sys), .rst(rst), .ras_n(ras_n), .cas_n(cas_n), .cbr_cnt(cbr_cnt),
		.gap(gap), .cas_to_ras(cas_to_ras), .cas_w(cas_w), .ras_w(ras_w)
	);

	// ==========================================================
	// clock and watchdog
	// ==========================================================
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// whole run is under two thousand clocks; twenty thousand means a hang
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end

	// ==========================================================
	// shared tasks
	// ==========================================================
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one single ahb transfer; holds each phase until hready is seen high
	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {14'h0, idx, 2'h0};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'h2;
		// only the watchdog ends a wait for ready
		do begin
			@(posedge clk_sys);
		end while (hreadyout !== 1'b1);
		// select drops with the address phase, so a next call never toggles it twice
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk_sys);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
	endtask

	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d);
		mreg[idx] = d;
	endtask

	// waits for n more refresh cycles, bounded
	task automatic wait_cbr(input int n);
		int start;
		int k;
		start = cbr_cnt;
		k = 0;
		while (cbr_cnt < start + n && k < 2000) begin
			@(posedge clk_sys);
			k++;
		end
		chk(32'(k < 2000), 32'h1);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	// ==========================================================
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		error_cnt = 0;
		total_checks = 0;
		en_b = 32'h1 << CTRL_EN_BIT;
		mreg[IDX_PERIOD] = {24'h0, PERIOD_RST};
		mreg[IDX_CTRL] = {29'h0, CTRL_RST};
		void'($urandom(24));
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);

		// reset values, read-back, unmapped place
		bus(1'b0, IDX_PERIOD, 32'h0);
		chk(rd, mreg[IDX_PERIOD]);
		bus(1'b0, IDX_CTRL, 32'h0);
		chk(rd, mreg[IDX_CTRL]);
		bus(1'b0, IDX_FLAG, 32'h0);
		chk(rd, 32'h0);
		wr(16'hfed6, 32'hffff_ffff);
		bus(1'b0, 16'hfed6, 32'h0);
		chk(rd, 32'h0);
		p = $urandom_range(80, 40);
		v = $urandom_range(20, 0);
		wr(IDX_PERIOD, 32'(p));
		bus(1'b0, IDX_PERIOD, 32'h0);
		chk(rd, mreg[IDX_PERIOD]);
		wr(IDX_COUNTER, 32'(v));
		bus(1'b0, IDX_COUNTER, 32'h0);
		// the read is taken the edge after the write lands, before any count
		chk(rd, 32'(v));
		$display("test registers done");

		// cas-before-ras refresh, without and with the wait state
		for (int w = 0; w < 2; w++) begin
			wr(IDX_CTRL, en_b | (32'(w) << CTRL_WAIT_BIT));
			wait_cbr(3);
			chk(32'(gap), 32'(p + 1));
			chk(32'(cas_to_ras), 32'(w));
			chk(32'(cas_w), 32'(2 + w));
			chk(32'(ras_w), 32'h3);
		end
		bus(1'b0, IDX_IRQ_ST, 32'h0);
		chk(rd & 32'h2, 32'h2);
		$display("test refresh done");

		// enable clear: nothing happens for any mode or wait choice
		for (int m = 0; m < 4; m++) begin
			wr(IDX_CTRL, 32'(m));
			repeat (2) @(posedge clk_sys);
			snap = cbr_cnt;
			repeat (2 * (p + 1)) @(posedge clk_sys);
			#1;
			chk(32'(cbr_cnt), 32'(snap));
			chk({30'h0, ras_n, cas_n}, 32'h3);
		end
		$display("test disable done");

		// self-refresh: both strobes held, no refresh cycles
		wr(IDX_CTRL, en_b | (32'h1 << CTRL_SELF_BIT));
		repeat (4) @(posedge clk_sys);
		snap = cbr_cnt;
		repeat (p + 10) @(posedge clk_sys);
		#1;
		chk({30'h0, ras_n, cas_n}, 32'h0);
		chk(32'(cbr_cnt), 32'(snap));
		wr(IDX_CTRL, 32'h0);
		repeat (4) @(posedge clk_sys);
		#1;
		chk({30'h0, ras_n, cas_n}, 32'h3);
		$display("test self done");

		// compare flag and interrupt; long period leaves room before the next match
		wr(IDX_PERIOD, 32'hff);
		wr(IDX_COUNTER, 32'h0);
		// a mask bit set lets its event through to the line
		wr(IDX_IRQ_MSK, 32'h3);
		wr(IDX_IRQ_ST, 32'h3);
		repeat (270) @(posedge clk_sys);
		#1;
		chk({31'h0, irq}, 32'h1);
		bus(1'b0, IDX_IRQ_ST, 32'h0);
		chk(rd, 32'h1);
		wr(IDX_IRQ_MSK, 32'h0);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({31'h0, irq}, 32'h0);
		// line comes back with the mask, then goes with the write-one clear
		wr(IDX_IRQ_MSK, 32'h1);
		wr(IDX_IRQ_ST, 32'h1);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({31'h0, irq}, 32'h0);
		// a write without the arming read leaves the flag set
		wr(IDX_FLAG, 32'h0);
		bus(1'b0, IDX_FLAG, 32'h0);
		chk(rd, 32'h1);
		wr(IDX_FLAG, 32'h0);
		bus(1'b0, IDX_FLAG, 32'h0);
		chk(rd, 32'h0);
		$display("test flag done");
		close_out();
	end
endmodule
